// *** core/fsps_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fsps_consts.svh"
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int PAGE_WORDS = 128,
  parameter int WORD_BITS = 7,
  parameter int PROG_CYCLES = (`FSPS_PROG_MIN_NS + `FSPS_CLK_NS - 1) / `FSPS_CLK_NS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  input wire logic store_program_instr,
  input wire logic load_program_instr,
  input wire logic [15:0] flash_address_pointer,
  input wire logic [15:0] reg_pair_data,
  input wire logic eeprom_write_busy,
  input wire logic int_enable,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic [7:0] fuse_extended_byte,
  input wire logic [7:0] lock_bits_in,
  input wire logic [14:0] fetch_addr,
  output logic cpu_halt,
  output logic rww_read_block,
  output logic lpm_hit,
  output logic [7:0] lpm_data,
  output logic flash_erase_go,
  output logic flash_write_go,
  output logic flash_lock_go,
  output logic [15:0] flash_page_addr,
  output logic [7:0] lock_prog_data,
  output logic [PAGE_WORDS*16-1:0] page_buffer,
  output logic [PAGE_WORDS-1:0] buffer_valid,
  output logic self_prog_irq
);
  // counter wide enough for the programming time; a faster clock needs a larger count
  localparam int PCNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [PCNT_W-1:0] PROG_LAST = PCNT_W'(PROG_CYCLES - 1);
  localparam int PROG_MAX_CYC = `FSPS_PROG_MAX_NS / `FSPS_CLK_NS;
  // window count at and below which a load is too late; stores still count down to one
  localparam logic [2:0] LOAD_LAST = `FSPS_STORE_WIN - `FSPS_LOAD_WIN;

  initial begin
    if (PAGE_WORDS != (1 << WORD_BITS) || PROG_CYCLES < 1 || PROG_CYCLES > PROG_MAX_CYC) begin
      $error("fsps_sequencer: unsupported parameters");
    end
  end

  // ==========================================================
  // state
  typedef struct packed {
    fsps_state_t st;
    fsps_op_t op;
    logic [2:0] win;
    logic en;
    logic lock;
    logic rww_busy;
    logic no_read_while_write_region_target;
    logic [PCNT_W-1:0] cnt;
    logic [15:0] page;
    logic [7:0] lockd;
    logic erase_go;
    logic write_go;
    logic lock_go;
    logic lpm_hit;
    logic [7:0] lpm_data;
    logic [PAGE_WORDS*16-1:0] buf_data;
    logic [PAGE_WORDS-1:0] buf_valid;
  } fsps_state_s_t;

  fsps_state_s_t s_q;
  fsps_state_s_t s_d;

  // decode the written control byte into an operation
  function automatic fsps_op_t fsps_decode(input logic [7:0] v);
    logic [7:0] m;
    m = v & `FSPS_CMD_MASK;
    if (m == `FSPS_CMD_ERASE) fsps_decode = FSPS_OP_ERASE;
    else if (m == `FSPS_CMD_WRITE) fsps_decode = FSPS_OP_WRITE;
    else if (m == `FSPS_CMD_LOAD) fsps_decode = FSPS_OP_LOAD;
    else if (m == `FSPS_CMD_LOCK) fsps_decode = FSPS_OP_LOCK;
    else if (m == `FSPS_CMD_REEN) fsps_decode = FSPS_OP_REEN;
    else fsps_decode = FSPS_OP_NONE;
  endfunction : fsps_decode

  // fuse or lock byte picked by the pointer; programmed bits are already zero
  function automatic logic [7:0] fsps_readback(input logic [15:0] p);
    if (p == `FSPS_PTR_FUSE_LO) fsps_readback = fuse_low_byte;
    else if (p == `FSPS_PTR_LOCK) fsps_readback = lock_bits_in;
    else if (p == `FSPS_PTR_FUSE_EXT) fsps_readback = fuse_extended_byte & `FSPS_EXT_MASK;
    else if (p == `FSPS_PTR_FUSE_HI) fsps_readback = fuse_high_byte;
    else fsps_readback = `FSPS_ALL_ONES;
  endfunction : fsps_readback

  // byte bit 0 of the pointer is skipped; the word index sits just above it
  logic [WORD_BITS-1:0] word_idx;
  logic prog_done;
  assign word_idx = flash_address_pointer[WORD_BITS:1];
  assign prog_done = (s_q.st == FSPS_BUSY) && (s_q.cnt == PROG_LAST);

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.erase_go = 1'b0;
    s_d.write_go = 1'b0;
    s_d.lock_go = 1'b0;
    s_d.lpm_hit = 1'b0;
    case (s_q.st)
      FSPS_IDLE: begin
        // eeprom write refuses the control write entirely
        if (ctrl_we && !eeprom_write_busy && ctrl_wdata[`FSPS_CR_ENABLE]) begin
          s_d.op = fsps_decode(ctrl_wdata);
          s_d.en = 1'b1;
          s_d.lock = ctrl_wdata[`FSPS_CR_LOCK];
          s_d.win = `FSPS_STORE_WIN;
          s_d.st = FSPS_ARMED;
          if (ctrl_wdata[`FSPS_CR_LOCK] && !ctrl_wdata[`FSPS_CR_ERASE]
              && !ctrl_wdata[`FSPS_CR_WRITE] && !ctrl_wdata[`FSPS_CR_REENABLE]) begin
            s_d.op = FSPS_OP_LOCK;
          end
        end
      end
      FSPS_ARMED: begin
        if (eeprom_write_busy) begin
          s_d.st = FSPS_IDLE;
          s_d.en = 1'b0;
          s_d.lock = 1'b0;
        end else if (load_program_instr && s_q.lock && s_q.win > LOAD_LAST) begin
          // readback only inside the three-cycle window
          s_d.lpm_hit = 1'b1;
          s_d.lpm_data = fsps_readback(flash_address_pointer);
          s_d.st = FSPS_IDLE;
          s_d.en = 1'b0;
          s_d.lock = 1'b0;
        end else if (store_program_instr) begin
          s_d.st = FSPS_IDLE;
          s_d.en = 1'b0;
          s_d.lock = 1'b0;
          case (s_q.op)
            FSPS_OP_ERASE, FSPS_OP_WRITE: begin
              // latch the page; erase and write both need the busy region
              s_d.page = flash_address_pointer;
              s_d.no_read_while_write_region_target = (flash_address_pointer[15:1] >= `FSPS_NO_READ_WHILE_WRITE_REGION_START);
              s_d.rww_busy = 1'b1;
              s_d.erase_go = (s_q.op == FSPS_OP_ERASE);
              s_d.write_go = (s_q.op == FSPS_OP_WRITE);
              s_d.cnt = '0;
              s_d.en = 1'b1;
              s_d.st = FSPS_BUSY;
            end
            FSPS_OP_LOCK: begin
              s_d.lockd = reg_pair_data[7:0];
              s_d.no_read_while_write_region_target = 1'b0;
              s_d.lock_go = 1'b1;
              s_d.cnt = '0;
              s_d.en = 1'b1;
              s_d.lock = 1'b1;
              s_d.st = FSPS_BUSY;
            end
            FSPS_OP_LOAD: begin
              // each load overwrites its slot, even a valid one; no merge of reloads
              s_d.buf_data[word_idx*16 +: 16] = reg_pair_data;
              s_d.buf_valid[word_idx] = 1'b1;
            end
            FSPS_OP_REEN: begin
              s_d.rww_busy = 1'b0;
              s_d.buf_data = '0;
              s_d.buf_valid = '0;
            end
            default: begin
            end
          endcase
        end else if (s_q.win == 3'h1) begin
          // window lapsed: enable and lock bits drop
          s_d.st = FSPS_IDLE;
          s_d.en = 1'b0;
          s_d.lock = 1'b0;
        end else begin
          s_d.win = s_q.win - 3'h1;
        end
      end
      FSPS_BUSY: begin
        // programming time counted in cycles
        if (prog_done) begin
          s_d.st = FSPS_IDLE;
          s_d.en = 1'b0;
          s_d.lock = 1'b0;
          if (s_q.op == FSPS_OP_WRITE) begin
            s_d.buf_data = '0;
            s_d.buf_valid = '0;
          end
        end else begin
          s_d.cnt = s_q.cnt + PCNT_W'(1);
        end
      end
      default: begin
        s_d.st = FSPS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers; reset also empties the buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.lpm_data <= `FSPS_ALL_ONES;
      s_q.lockd <= `FSPS_ALL_ONES;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  // lock programming never halts the cpu and never sets the rww busy flag
  logic prog_flash;
  assign prog_flash = (s_q.st == FSPS_BUSY) && (s_q.op != FSPS_OP_LOCK);
  assign cpu_halt = prog_flash && s_q.no_read_while_write_region_target;
  assign rww_read_block = s_q.rww_busy;
  assign self_prog_irq = int_enable && !s_q.en;
  assign ctrl_rdata = {1'b0, s_q.rww_busy, 1'b0, 1'b0, s_q.lock,
                       (s_q.op == FSPS_OP_WRITE) & s_q.en,
                       (s_q.op == FSPS_OP_ERASE) & s_q.en, s_q.en};
  assign lpm_hit = s_q.lpm_hit;
  assign lpm_data = s_q.lpm_data;
  assign flash_erase_go = s_q.erase_go;
  assign flash_write_go = s_q.write_go;
  assign flash_lock_go = s_q.lock_go;
  assign flash_page_addr = s_q.page;
  assign lock_prog_data = s_q.lockd;
  assign page_buffer = s_q.buf_data;
  assign buffer_valid = s_q.buf_valid;

  // ==========================================================
  // checks
  sequence seq_start_flash;
    s_q.st == FSPS_ARMED && store_program_instr && !eeprom_write_busy
      && !(load_program_instr && s_q.lock && s_q.win > 3'h1)
      && (s_q.op == FSPS_OP_ERASE || s_q.op == FSPS_OP_WRITE);
  endsequence

  chk_busy_on_start: assert property (@(posedge clk) disable iff (!reset_n)
    seq_start_flash |=> rww_read_block && s_q.en)
    else $error("busy flag not set on programming start");
  chk_irq_follows_en: assert property (@(posedge clk) disable iff (!reset_n)
    self_prog_irq == (int_enable && !ctrl_rdata[`FSPS_CR_ENABLE]))
    else $error("interrupt does not follow enable bit");

  // quiet window: armed with a full window and no instruction on any of its four edges
  sequence seq_quiet_window;
    s_q.st == FSPS_ARMED && s_q.win == `FSPS_STORE_WIN && !store_program_instr
      && !load_program_instr
      ##1 (!store_program_instr && !load_program_instr) [*3];
  endsequence

  chk_window_expiry: assert property (@(posedge clk) disable iff (!reset_n)
    seq_quiet_window |=> !s_q.en && !s_q.lock)
    else $error("enable bit outlived the timed window");
  chk_eeprom_refuse: assert property (@(posedge clk) disable iff (!reset_n)
    eeprom_write_busy |=> !flash_erase_go && !flash_write_go && !flash_lock_go && !lpm_hit)
    else $error("operation started during eeprom write");
  chk_busy_held: assert property (@(posedge clk) disable iff (!reset_n)
    rww_read_block && !(s_q.st == FSPS_ARMED && s_q.op == FSPS_OP_REEN) |=> rww_read_block)
    else $error("busy flag cleared without reenable");
  chk_lock_no_halt: assert property (@(posedge clk) disable iff (!reset_n)
    flash_lock_go |-> !cpu_halt [*8])
    else $error("lock programming halted the cpu");
  chk_write_clears: assert property (@(posedge clk) disable iff (!reset_n)
    prog_done && s_q.op == FSPS_OP_WRITE |=> buffer_valid == '0)
    else $error("buffer not cleared after page write");
  chk_prog_length: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.st == FSPS_BUSY && !prog_done |=> s_q.st == FSPS_BUSY && ctrl_rdata[`FSPS_CR_ENABLE])
    else $error("programming ended before its time");
  chk_done_drops_en: assert property (@(posedge clk) disable iff (!reset_n)
    prog_done |=> !ctrl_rdata[`FSPS_CR_ENABLE] && s_q.st == FSPS_IDLE)
    else $error("enable bit held after programming");
  chk_ext_mask: assert property (@(posedge clk) disable iff (!reset_n)
    lpm_hit && $past(flash_address_pointer) == `FSPS_PTR_FUSE_EXT |-> lpm_data[7:2] == 6'h00)
    else $error("extended fuse upper bits not masked");

  // ==========================================================
  // readback: a load with the lock access bit set, inside its three edges
  sequence seq_readback_taken;
    s_q.st == FSPS_ARMED && s_q.lock && load_program_instr && !eeprom_write_busy
      && s_q.win > LOAD_LAST;
  endsequence

  chk_readback_hit: assert property (@(posedge clk) disable iff (!reset_n)
    seq_readback_taken |=> lpm_hit && !ctrl_rdata[`FSPS_CR_ENABLE] && !ctrl_rdata[`FSPS_CR_LOCK])
    else $error("readback not answered or bits left set");

  // re-enable command: store taken while armed with the re-enable code
  sequence seq_reenable_taken;
    s_q.st == FSPS_ARMED && s_q.op == FSPS_OP_REEN && store_program_instr && !eeprom_write_busy;
  endsequence

  chk_reenable_clears: assert property (@(posedge clk) disable iff (!reset_n)
    seq_reenable_taken |=> !rww_read_block && buffer_valid == '0)
    else $error("re-enable left busy flag or buffer set");

  // buffer load: one store with the load code fills the slot named by the word index
  sequence seq_load_taken;
    s_q.st == FSPS_ARMED && s_q.op == FSPS_OP_LOAD && store_program_instr && !eeprom_write_busy;
  endsequence

  chk_load_fills: assert property (@(posedge clk) disable iff (!reset_n)
    seq_load_taken |=> buffer_valid[$past(word_idx)] && !ctrl_rdata[`FSPS_CR_ENABLE])
    else $error("buffer slot not filled by load");

  // halt follows the latched page, not the live pointer
  chk_no_read_while_write_region_halt: assert property (@(posedge clk) disable iff (!reset_n)
    seq_start_flash |=> cpu_halt == (flash_page_addr[15:1] >= `FSPS_NO_READ_WHILE_WRITE_REGION_START))
    else $error("cpu halt does not match target region");
  chk_lock_data: assert property (@(posedge clk) disable iff (!reset_n)
    flash_lock_go |-> lock_prog_data == $past(reg_pair_data[7:0]))
    else $error("lock data not taken from register pair");
  chk_go_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    flash_erase_go || flash_write_go || flash_lock_go
      |=> !flash_erase_go && !flash_write_go && !flash_lock_go)
    else $error("programming strobe longer than one cycle");
endmodule : fsps_sequencer
`default_nettype wire

// *** core/fsps_consts.svh ***
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH
// control register fields
`define FSPS_CR_ENABLE 0
`define FSPS_CR_ERASE 1
`define FSPS_CR_WRITE 2
`define FSPS_CR_LOCK 3
`define FSPS_CR_REENABLE 4
// command codes on bits 6:0 (bit 7 is a don't care)
`define FSPS_CMD_MASK 8'h7F
`define FSPS_CMD_ERASE 8'h03
`define FSPS_CMD_WRITE 8'h05
`define FSPS_CMD_LOAD 8'h01
`define FSPS_CMD_LOCK 8'h09
`define FSPS_CMD_REEN 8'h11
// timed windows in cycles
`define FSPS_STORE_WIN 3'h4
`define FSPS_LOAD_WIN 3'h3
// programming time
`define FSPS_PROG_MIN_NS 3700000
`define FSPS_PROG_MAX_NS 4500000
`define FSPS_CLK_NS 25
// region split on word address
`define FSPS_NO_READ_WHILE_WRITE_REGION_START 15'h7000
// readback pointers
`define FSPS_PTR_FUSE_LO 16'h0000
`define FSPS_PTR_LOCK 16'h0001
`define FSPS_PTR_FUSE_EXT 16'h0002
`define FSPS_PTR_FUSE_HI 16'h0003
// lock fields in the data byte, extended fuse mask and all-ones byte
`define FSPS_LOCK_LSB 2
`define FSPS_LOCK_MSB 5
`define FSPS_EXT_MASK 8'h03
`define FSPS_ALL_ONES 8'hFF
`endif

// *** core/fsps_pkg.sv ***
package fsps_pkg;
  typedef enum logic [2:0] {
    FSPS_IDLE = 3'b000,
    FSPS_ARMED = 3'b001,
    FSPS_BUSY = 3'b010
  } fsps_state_t;
  typedef enum logic [2:0] {
    FSPS_OP_NONE = 3'b000,
    FSPS_OP_ERASE = 3'b001,
    FSPS_OP_WRITE = 3'b010,
    FSPS_OP_LOAD = 3'b011,
    FSPS_OP_LOCK = 3'b100,
    FSPS_OP_READ = 3'b101,
    FSPS_OP_REEN = 3'b110
  } fsps_op_t;
endpackage : fsps_pkg

// *** bench/fsps_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// cpu core side: timed control write, then a store or load instruction
module fsps_cpu_model (
  input wire logic clk,
  output logic ctrl_we,
  output logic [7:0] ctrl_wdata,
  output logic store_program_instr,
  output logic load_program_instr,
  output logic [15:0] flash_address_pointer,
  output logic [15:0] reg_pair_data
);
  initial begin
    ctrl_we = 1'b0;
    ctrl_wdata = 8'h00;
    store_program_instr = 1'b0;
    load_program_instr = 1'b0;
    flash_address_pointer = 16'h0000;
    reg_pair_data = 16'h0000;
  end
  // no interrupt can stretch the gap, so the window is kept exactly
  // gap 4 for stores and 3 for loads is the last legal slot
  // callers keep word bits zero for page ops and R0 spare bits one
  task automatic issue(input logic [7:0] cmd, input logic [15:0] ptr, input logic [15:0] dat,
      input int gap, input logic is_load);
    @(negedge clk);
    ctrl_we = 1'b1;
    ctrl_wdata = cmd;
    flash_address_pointer = ptr;
    reg_pair_data = dat;
    repeat (gap) begin
      @(negedge clk);
      ctrl_we = 1'b0;
    end
    if (is_load) load_program_instr = 1'b1;
    else store_program_instr = 1'b1;
    @(negedge clk);
    store_program_instr = 1'b0;
    load_program_instr = 1'b0;
    // released lines show the inverse so stale values are never trusted
    ctrl_wdata = ~cmd;
    reg_pair_data = ~dat;
    flash_address_pointer = ~ptr;
  endtask : issue
endmodule : fsps_cpu_model
`default_nettype wire

// *** bench/fsps_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsps_tb_top;
  import fsps_pkg::*;
  localparam int PC = 8;
  logic clk, reset_n, eeprom_write_busy, int_enable, ctrl_we, store_i, load_i;
  logic cpu_halt, rww_read_block, lpm_hit, erase_go, write_go, lock_go, self_prog_irq;
  logic [7:0] ctrl_wdata, ctrl_rdata, lpm_data, lock_prog_data;
  logic [7:0] fuse_lo = 8'h5E, fuse_hi = 8'h99, fuse_ext = 8'hFD, lock_in = 8'hEC;
  logic [15:0] ptr, rdat, page_addr, go_addr;
  logic [2047:0] page_buffer;
  logic [127:0] buffer_valid;
  int num_errors = 0, tests_run = 0, n_erase, n_write, n_lock, n_hit;
  fsps_cpu_model cpu (.clk(clk), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .store_program_instr(store_i), .load_program_instr(load_i),
    .flash_address_pointer(ptr), .reg_pair_data(rdat));
  fsps_sequencer #(.PROG_CYCLES(PC)) uut (.clk(clk), .reset_n(reset_n), .ctrl_we(ctrl_we),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .store_program_instr(store_i),
    .load_program_instr(load_i), .flash_address_pointer(ptr), .reg_pair_data(rdat),
    .eeprom_write_busy(eeprom_write_busy), .int_enable(int_enable), .fuse_low_byte(fuse_lo),
    .fuse_high_byte(fuse_hi), .fuse_extended_byte(fuse_ext), .lock_bits_in(lock_in),
    .fetch_addr(15'h0000), .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
    .lpm_hit(lpm_hit), .lpm_data(lpm_data), .flash_erase_go(erase_go),
    .flash_write_go(write_go), .flash_lock_go(lock_go), .flash_page_addr(page_addr),
    .lock_prog_data(lock_prog_data), .page_buffer(page_buffer), .buffer_valid(buffer_valid),
    .self_prog_irq(self_prog_irq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ====================
  // pulse counters, so the exact cycle of a go pulse does not matter
  always @(posedge clk) begin
    if (erase_go === 1'b1) n_erase++;
    if (write_go === 1'b1) n_write++;
    if (lock_go === 1'b1) n_lock++;
    if (lpm_hit === 1'b1) n_hit++;
    if ((erase_go | write_go) === 1'b1) go_addr <= page_addr;
  end
  task automatic zero;
    n_erase = 0;
    n_write = 0;
    n_lock = 0;
    n_hit = 0;
  endtask : zero
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // bounded wait for the enable bit to drop
  task automatic wait_done;
    int i;
    i = 0;
    while (ctrl_rdata[0] !== 1'b0 && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (i >= 100) begin
      num_errors++;
      conclude();
    end else begin
      check(i, PC);
    end
  endtask : wait_done
  // ====================
  // scenarios
  task automatic s_erase;
    zero();
    cpu.issue(8'h03, 16'h0200, 16'hA5A5, 4, 1'b0);
    check(ctrl_rdata[0], 1'b1);
    check({rww_read_block, cpu_halt, self_prog_irq}, 3'b100);
    wait_done();
    check({n_erase, go_addr}, {32'd1, 16'h0200});
    check({self_prog_irq, rww_read_block}, 2'b11);
    int_enable = 1'b0;
    @(negedge clk);
    check(self_prog_irq, 1'b0);
    zero();
    cpu.issue(8'h03, 16'h0200, 16'h0000, 5, 1'b0);
    repeat (2) @(negedge clk);
    check({n_erase, ctrl_rdata[3:0]}, 36'h0);
  endtask : s_erase
  task automatic s_load;
    cpu.issue(8'h01, 16'h0006, 16'h1234, 1, 1'b0);
    repeat (2) @(negedge clk);
    check({page_buffer[48+:16], buffer_valid[3]}, {16'h1234, 1'b1});
    cpu.issue(8'h11, 16'h0000, 16'h0000, 2, 1'b0);
    check(ctrl_rdata[0], 1'b0);
    check({buffer_valid, rww_read_block}, 129'h0);
    cpu.issue(8'h01, 16'h0000, 16'h00FF, 3, 1'b0);
    repeat (2) @(negedge clk);
    check({page_buffer[15:0], buffer_valid}, {16'h00FF, 128'h1});
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    check(buffer_valid, 128'h0);
  endtask : s_load
  task automatic s_write;
    zero();
    cpu.issue(8'h01, 16'hE00A, 16'hBEEF, 2, 1'b0);
    cpu.issue(8'h03, 16'hE000, 16'h0000, 3, 1'b0);
    check(cpu_halt, 1'b1);
    wait_done();
    cpu.issue(8'h85, 16'hE000, 16'h0000, 4, 1'b0);
    check({cpu_halt, page_buffer[80+:16]}, {1'b1, 16'hBEEF});
    wait_done();
    check({n_write, go_addr, buffer_valid, cpu_halt}, {32'd1, 16'hE000, 129'h0});
    check(rww_read_block, 1'b1);
    cpu.issue(8'h11, 16'h0000, 16'h0000, 1, 1'b0);
    check(rww_read_block, 1'b0);
  endtask : s_write
  task automatic s_lock;
    zero();
    cpu.issue(8'h09, 16'h0001, 16'h00C3, 2, 1'b0);
    check({rww_read_block, cpu_halt}, 2'b00);
    wait_done();
    check({n_lock, lock_prog_data}, {32'd1, 8'hC3});
  endtask : s_lock
  task automatic s_read;
    logic [7:0] exp [4];
    exp = '{fuse_lo, lock_in, fuse_ext, fuse_hi};
    for (int p = 0; p < 4; p++) begin
      zero();
      cpu.issue(8'h09, p[15:0], 16'h0000, 3, 1'b1);
      repeat (2) @(negedge clk);
      check(n_hit, 1);
      if (p == 2) check(lpm_data & 8'h03, exp[p] & 8'h03);
      else check(lpm_data, exp[p]);
      check(ctrl_rdata[3:0], 4'h0);
    end
  endtask : s_read
  task automatic s_eeprom;
    zero();
    eeprom_write_busy = 1'b1;
    cpu.issue(8'h03, 16'h0100, 16'h0000, 1, 1'b0);
    cpu.issue(8'h09, 16'h0000, 16'h0000, 1, 1'b1);
    repeat (2) @(negedge clk);
    check({n_erase, n_hit, ctrl_rdata[3:0]}, 68'h0);
    eeprom_write_busy = 1'b0;
    // eeprom write starting inside the window disarms the armed command
    fork
      cpu.issue(8'h03, 16'h0100, 16'h0000, 3, 1'b0);
      begin
        repeat (2) @(negedge clk);
        eeprom_write_busy = 1'b1;
      end
    join
    repeat (2) @(negedge clk);
    check({n_erase, ctrl_rdata[3:0]}, 36'h0);
    eeprom_write_busy = 1'b0;
  endtask : s_eeprom
  initial begin
    reset_n = 1'b0;
    eeprom_write_busy = 1'b0; // software waits for the eeprom before control writes
    int_enable = 1'b1;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    check({ctrl_rdata, lpm_data, buffer_valid, self_prog_irq}, {16'h00FF, 128'h0, 1'b1});
    s_erase();
    s_load();
    s_write();
    s_lock();
    s_read();
    s_eeprom();
    conclude();
  end
endmodule : fsps_tb_top
`default_nettype wire
